// ===== eq_ctrl_pkg.sv
// constants for the quad equalizer channel control block
// assumes one byte-wide register port driven by an external serial slave
`default_nettype none
package eq_ctrl_pkg;
  localparam logic [7:0] STATUS_ADDR      = 8'h00;
  localparam logic [7:0] STAT01_ADDR      = 8'h01;
  localparam logic [7:0] STAT23_ADDR      = 8'h02;
  localparam logic [7:0] CTRL01_ADDR      = 8'h03;
  localparam logic [7:0] CTRL23_ADDR      = 8'h04;
  localparam logic [7:0] PRESENT_THR_ADDR = 8'h05;
  localparam logic [7:0] LOST_THR_ADDR    = 8'h06;
  localparam logic [7:0] SELECTOR_ADDR    = 8'h07;
  localparam logic [7:0] AMPLITUDE_ADDR   = 8'h08;
  localparam logic [7:0] CTRL_RESET       = 8'h44;
  localparam logic [7:0] THR_RESET        = 8'h00;
  localparam logic [7:0] SELECTOR_RESET   = 8'h00;
  localparam logic [7:0] AMPLITUDE_RESET  = 8'h78;
  localparam logic [7:0] SELECTOR_MASK    = 8'h01;
  localparam logic [7:0] AMPLITUDE_MASK   = 8'h0c;
  localparam logic [2:0] BOOST_DEFAULT    = 3'h4;
  localparam int         AMP_LSB          = 2;
  localparam int         EN_BIT           = 3;
  localparam int         NCH              = 4;
endpackage : eq_ctrl_pkg
`default_nettype wire

// ===== eq_ctrl.sv
// register bank and channel control for a four-channel equalizer
// assumes a serial slave presents byte writes and reads on the register port
`timescale 1ns/1ns
`default_nettype none
module eq_ctrl
  import eq_ctrl_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       clk_en_i,
  input  wire logic       boost_source_select_i,
  input  wire logic [2:0] shared_boost_level_pins_i,
  input  wire logic [3:0] channel_enable_input_i,
  input  wire logic [3:0] above_present_i,
  input  wire logic [3:0] below_lost_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic      [3:0] channel_signal_present_o,
  output logic      [3:0] channel_active_o,
  output logic     [11:0] channel_boost_o,
  output logic      [7:0] present_threshold_o,
  output logic      [7:0] signal_lost_threshold_o,
  output logic      [1:0] amplitude_o
);
  typedef struct packed {
    logic [7:0]  ctrl01;
    logic [7:0]  ctrl23;
    logic [7:0]  present_thr;
    logic [7:0]  lost_thr;
    logic [7:0]  selector;
    logic [7:0]  amplitude;
    logic [3:0]  present;
    logic [3:0]  active;
    logic [11:0] boost;
    logic [7:0]  rdata;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // register enable bit of channel n, 1 meaning standby
  function automatic logic reg_standby(input logic [15:0] c, input int n);
    reg_standby = c[n*4+EN_BIT];
  endfunction : reg_standby

  function automatic logic [2:0] reg_boost(input logic [15:0] c, input int n);
    reg_boost = c[n*4+:3];
  endfunction : reg_boost

  logic [15:0] ctrl_w;
  assign ctrl_w = {st_r.ctrl23, st_r.ctrl01};

  always_comb begin
    st_nxt = st_r;
    for (int n = 0; n < NCH; n++) begin
      if (above_present_i[n]) begin
        st_nxt.present[n] = 1'b1;
      end else if (below_lost_i[n]) begin
        st_nxt.present[n] = 1'b0;
      end
      if (st_r.selector[0]) begin
        st_nxt.active[n] = ~reg_standby(ctrl_w, n);
      end else begin
        st_nxt.active[n] = channel_enable_input_i[n];
      end
      if (boost_source_select_i) begin
        st_nxt.boost[n*3+:3] = shared_boost_level_pins_i;
      end else begin
        st_nxt.boost[n*3+:3] = reg_boost(ctrl_w, n);
      end
    end
    if (reg_wr_i) begin
      if (reg_addr_i == CTRL01_ADDR) begin
        st_nxt.ctrl01 = reg_wdata_i;
      end else if (reg_addr_i == CTRL23_ADDR) begin
        st_nxt.ctrl23 = reg_wdata_i;
      end else if (reg_addr_i == PRESENT_THR_ADDR) begin
        st_nxt.present_thr = reg_wdata_i;
      end else if (reg_addr_i == LOST_THR_ADDR) begin
        st_nxt.lost_thr = reg_wdata_i;
      end else if (reg_addr_i == SELECTOR_ADDR) begin
        st_nxt.selector = reg_wdata_i & SELECTOR_MASK;
      end else if (reg_addr_i == AMPLITUDE_ADDR) begin
        st_nxt.amplitude = (reg_wdata_i & AMPLITUDE_MASK) | (st_r.amplitude & ~AMPLITUDE_MASK);
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == STATUS_ADDR) begin
        st_nxt.rdata = {4'h0, st_r.present};
      end else if (reg_addr_i == STAT01_ADDR) begin
        st_nxt.rdata = {~st_r.active[1], st_r.boost[5:3], ~st_r.active[0], st_r.boost[2:0]};
      end else if (reg_addr_i == STAT23_ADDR) begin
        st_nxt.rdata = {~st_r.active[3], st_r.boost[11:9], ~st_r.active[2], st_r.boost[8:6]};
      end else if (reg_addr_i == CTRL01_ADDR) begin
        st_nxt.rdata = st_r.ctrl01;
      end else if (reg_addr_i == CTRL23_ADDR) begin
        st_nxt.rdata = st_r.ctrl23;
      end else if (reg_addr_i == PRESENT_THR_ADDR) begin
        st_nxt.rdata = st_r.present_thr;
      end else if (reg_addr_i == LOST_THR_ADDR) begin
        st_nxt.rdata = st_r.lost_thr;
      end else if (reg_addr_i == SELECTOR_ADDR) begin
        st_nxt.rdata = st_r.selector;
      end else if (reg_addr_i == AMPLITUDE_ADDR) begin
        st_nxt.rdata = st_r.amplitude;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r.ctrl01      <= CTRL_RESET;
      st_r.ctrl23      <= CTRL_RESET;
      st_r.present_thr <= THR_RESET;
      st_r.lost_thr    <= THR_RESET;
      st_r.selector    <= SELECTOR_RESET;
      st_r.amplitude   <= AMPLITUDE_RESET;
      st_r.present     <= 4'h0;
      st_r.active      <= 4'h0;
      st_r.boost       <= {NCH{BOOST_DEFAULT}};
      st_r.rdata       <= 8'h00;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o              = st_r.rdata;
  assign channel_signal_present_o = st_r.present;
  assign channel_active_o         = st_r.active;
  assign channel_boost_o          = st_r.boost;
  assign present_threshold_o      = st_r.present_thr;
  assign signal_lost_threshold_o  = st_r.lost_thr;
  assign amplitude_o              = st_r.amplitude[AMP_LSB+:2];

  // pull-up is a pad cell; the core only sees the resolved level

  // sampled reset term keeps the release edge out of the antecedent
  // shared boost
  pin_boost_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !reset_i && clk_en_i && boost_source_select_i
      |=> channel_boost_o[2:0] == $past(shared_boost_level_pins_i)
      && channel_boost_o[11:9] == $past(shared_boost_level_pins_i))
    else $error("pin boost not applied");
  reg_boost_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && !boost_source_select_i |=> channel_boost_o[8:6] == $past(st_r.ctrl23[2:0]))
    else $error("register boost not applied");
  pin_enable_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !reset_i && clk_en_i && !st_r.selector[0]
      |=> channel_active_o == $past(channel_enable_input_i))
    else $error("pin enable not followed");
  reg_enable_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && st_r.selector[0] |=> channel_active_o[3] == !$past(st_r.ctrl23[7]))
    else $error("register enable not followed");
  sequence selector_set_s;
    clk_en_i && reg_wr_i && reg_addr_i == SELECTOR_ADDR && reg_wdata_i[0];
  endsequence
  sequence enable_on_s;
    clk_en_i && !reset_i;
  endsequence
  sel_handover_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    selector_set_s ##1 enable_on_s |=> channel_active_o[0] == !$past(st_r.ctrl01[EN_BIT]))
    else $error("register enable not taken over");
  amp_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && reg_wr_i && reg_addr_i == AMPLITUDE_ADDR |=> amplitude_o == $past(reg_wdata_i[3:2])
      && st_r.amplitude[7:4] == 4'h7)
    else $error("amplitude write wrong");
  detect_rise_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !reset_i && clk_en_i && above_present_i[0] |=> channel_signal_present_o[0])
    else $error("signal present missed");
  detect_fall_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && !above_present_i[1] && below_lost_i[1] |=> !channel_signal_present_o[1])
    else $error("signal loss missed");
  detect_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && !above_present_i[0] && !below_lost_i[0]
      |=> $stable(channel_signal_present_o[0]))
    else $error("signal present not held");
  standby_detect_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && !channel_active_o[2] && above_present_i[2] |=> channel_signal_present_o[2])
    else $error("standby channel lost detection");
  status_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && reg_rd_i && reg_addr_i == STATUS_ADDR
      |=> reg_rdata_o == {4'h0, $past(channel_signal_present_o)})
    else $error("status read wrong");
  thr_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && reg_wr_i && reg_addr_i == PRESENT_THR_ADDR
      |=> present_threshold_o == $past(reg_wdata_i))
    else $error("present threshold write wrong");
  sel_reserved_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ##1 st_r.selector[7:1] == 7'h00)
    else $error("reserved selector bits set");
  unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && reg_rd_i && reg_addr_i > AMPLITUDE_ADDR |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  reset_default_a: assert property (@(posedge core_clk_i)
    reset_i |=> channel_boost_o == {NCH{BOOST_DEFAULT}} && channel_active_o == 4'h0
      && amplitude_o == AMPLITUDE_RESET[AMP_LSB+:2])
    else $error("reset defaults wrong");
  lost_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && reg_wr_i && reg_addr_i == LOST_THR_ADDR
      |=> signal_lost_threshold_o == $past(reg_wdata_i))
    else $error("lost threshold write wrong");
endmodule : eq_ctrl
`default_nettype wire

// ===== host_model.sv
// partner: configuration pins and byte-strobe register host
// assumes requests are taken on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic       clk_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            src_o,
  output logic      [2:0] boost_pins_o,
  output logic      [3:0] en_o,
  output logic      [3:0] ap_o,
  output logic      [3:0] bl_o
);
  initial {src_o, wr_o, rd_o, addr_o, wdata_o, boost_pins_o, en_o, ap_o, bl_o} = {1'b1, 33'h0};
  // pins settle through the registered outputs before returning
  task automatic pins(input logic s, input logic [2:0] b, input logic [3:0] e, a, l);
    @(posedge clk_i);
    {src_o, boost_pins_o, en_o, ap_o, bl_o} <= {s, b, e, a, l};
    #81;
  endtask : pins
  // idle address and data show the inverse, not the last value
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
    @(posedge clk_i);
    {wr_o, rd_o, addr_o, wdata_o} <= {2'b00, ~a, ~d};
    #41;
  endtask : acc
endmodule : host_model
`default_nettype wire

// ===== tb_quad_equalizer_channel_control.sv
// self-checking bench for the quad equalizer channel control block
// assumes host_model drives all inputs but clock, reset and clock enable
`timescale 1ns/1ns
`default_nettype none
module tb_quad_equalizer_channel_control;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wr, rd, src;
  logic  [1:0] amp;
  logic  [2:0] shared_boost;
  logic  [3:0] en, ap, bl, pres, act;
  logic  [7:0] addr, wdata, rdata, pthr, lthr;
  logic [11:0] bo;
  int          failures = 0, compares = 0;
  always #20 clk = ~clk;
  eq_ctrl DUT (.core_clk_i(clk), .reset_i(rst), .clk_en_i(ce), .boost_source_select_i(src),
    .shared_boost_level_pins_i(shared_boost), .channel_enable_input_i(en),
    .above_present_i(ap), .below_lost_i(bl), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .channel_signal_present_o(pres),
    .channel_active_o(act), .channel_boost_o(bo), .present_threshold_o(pthr),
    .signal_lost_threshold_o(lthr), .amplitude_o(amp));
  host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
    .src_o(src), .boost_pins_o(shared_boost), .en_o(en), .ap_o(ap), .bl_o(bl));
  task automatic chk(input string n, input logic [11:0] e, g);
    compares++;
    if (g !== e) failures++;
    if (g !== e) $display("unexpected %s expected %h seen %h", n, e, g);
  endtask : chk
  task automatic rchk(input logic [7:0] a, e);
    host.acc(1'b0, a, 8'h00);
    chk("read", {4'h0, e}, {4'h0, rdata});
  endtask : rchk
  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic t_pin_boost();
    for (int i = 0; i < 8; i++) begin
      host.pins(1'b1, 3'(i), 4'hf, 4'h0, 4'h0);
      chk("boost", {4{3'(i)}}, bo);
    end
    chk("active", 12'h00f, {8'h0, act});
  endtask : t_pin_boost
  task automatic t_reg_control();
    host.pins(1'b0, 3'h7, 4'ha, 4'h0, 4'h0);
    rchk(8'h03, 8'h44);
    rchk(8'h08, 8'h78);
    chk("boost", 12'h924, bo);
    chk("active", 12'h00a, {8'h0, act});
    host.acc(1'b1, 8'h03, 8'h75);
    host.acc(1'b1, 8'h04, 8'h88);
    chk("boost", 12'h03d, bo);
    chk("active", 12'h00a, {8'h0, act});
    host.acc(1'b1, 8'h07, 8'h01);
    chk("active", 12'h003, {8'h0, act});
    rchk(8'h01, 8'h75);
    rchk(8'h02, 8'h88);
    host.pins(1'b0, 3'h7, 4'h5, 4'h0, 4'h0);
    chk("active", 12'h003, {8'h0, act});
  endtask : t_reg_control
  task automatic t_reserved();
    for (int c = 0; c < 4; c++) begin
      host.acc(1'b1, 8'h08, 8'hf3 | 8'(c << 2));
      rchk(8'h08, 8'h70 | 8'(c << 2));
      chk("amplitude", 12'(c), {10'h0, amp});
    end
    host.acc(1'b1, 8'h06, 8'he4);
    rchk(8'h06, 8'he4);
    chk("lost threshold", 12'h0e4, {4'h0, lthr});
    host.acc(1'b1, 8'h05, 8'h9c);
    rchk(8'h05, 8'h9c);
    chk("present threshold", 12'h09c, {4'h0, pthr});
    host.acc(1'b1, 8'h07, 8'hff);
    rchk(8'h07, 8'h01);
    host.acc(1'b1, 8'h02, 8'h00);
    rchk(8'h02, 8'h88);
    rchk(8'h09, 8'h00);
  endtask : t_reserved
  task automatic t_detect();
    host.pins(1'b0, 3'h0, 4'h0, 4'h5, 4'h0);
    chk("present", 12'h005, {8'h0, pres});
    rchk(8'h00, 8'h05);
    host.pins(1'b0, 3'h0, 4'h0, 4'h0, 4'h4);
    chk("present", 12'h001, {8'h0, pres});
    chk("active", 12'h003, {8'h0, act});
  endtask : t_detect
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    host.acc(1'b1, 8'h06, 8'h1b);
    host.pins(1'b1, 3'h6, 4'h0, 4'h0, 4'hf);
    chk("frozen boost", 12'h03d, bo);
    chk("frozen present", 12'h001, {8'h0, pres});
    chk("frozen threshold", 12'h0e4, {4'h0, lthr});
    @(posedge clk);
    ce <= 1'b1;
    host.pins(1'b1, 3'h6, 4'h0, 4'h0, 4'hf);
    chk("boost", 12'hdb6, bo);
    chk("present", 12'h000, {8'h0, pres});
    rchk(8'h06, 8'he4);
  endtask : t_freeze
  task automatic t_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h03, 8'h44);
    rchk(8'h07, 8'h00);
    rchk(8'h05, 8'h00);
    chk("active", 12'h000, {8'h0, act});
    chk("amplitude", 12'h002, {10'h0, amp});
    chk("lost threshold", 12'h000, {4'h0, lthr});
    chk("boost", 12'hdb6, bo);
  endtask : t_reset
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_pin_boost();
    t_reg_control();
    t_reserved();
    t_detect();
    t_freeze();
    t_reset();
    tally_and_finish();
  end
endmodule : tb_quad_equalizer_channel_control
`default_nettype wire
